/* File: rtl/pcc_pkg.sv */
// Constants and types for the parameter conflict checker.
// Assumes parameters are 16-bit codes and frequencies are kept in 0.1 Hz units.
package pcc_pkg;

    localparam int DATA_W = 16;

    // Which setting parameter a write targets, or which one caused a refusal
    typedef enum logic [3:0] {
        PAR_NONE,
        PAR_OP_CMD,
        PAR_SPEED1,
        PAR_UFL,
        PAR_MOTOR_TYPE,
        PAR_MCM,
        PAR_TQ_PR,
        PAR_TQ_RG,
        PAR_OP_MODE,
        PAR_AIN_SW,
        PAR_FEED_PUMP,
        PAR_PRS_CMD,
        PAR_PRS_UPPER,
        PAR_PRS_LOWER
    } pcc_param_t;

    // Motor control mode values
    localparam logic [15:0] MCM_FEED_PUMP   = 16'h0003;
    localparam logic [15:0] MCM_OPCMD_ONLY  = 16'h0004;
    localparam logic [15:0] MCM_VEC_FIRST   = 16'h0006;
    localparam logic [15:0] MCM_VEC_B       = 16'h000b;
    localparam logic [15:0] MCM_VEC_NO_POLE = 16'h000c;

    // Operation command and operation mode values
    localparam logic [15:0] OPCMD_REQ       = 16'h0002;
    localparam logic [15:0] OPMODE_ONE      = 16'h0001;
    localparam logic [15:0] OPMODE_TWO      = 16'h0002;
    localparam logic [15:0] OPMODE_THREE    = 16'h0003;

    // First speed setting values: 7..12 own every analog channel, from 2 up one channel is named
    localparam logic [15:0] SPEED1_EXCL_LO  = 16'h0007;
    localparam logic [15:0] SPEED1_EXCL_HI  = 16'h000c;
    localparam logic [15:0] SPEED1_SHARE_LO = 16'h0002;

    // Motor type codes 0..3 are 2, 4, 6 and 8 poles; vector modes allow only these
    localparam logic [15:0] VEC_MOTOR_TYPES = 16'h0004;

    // Upper frequency bounds in vector control, in Hz
    localparam int UFL_2P_HZ      = 60;
    localparam int UFL_4P_HZ      = 130;
    localparam int UFL_6P_HZ      = 200;
    localparam int UFL_8P_HZ      = 270;
    localparam int VEC_OP_MAX_HZ  = 120;
    localparam int FREQ_PER_HZ    = 10;

    localparam logic [15:0] UFL_2P_CNT  = 16'(UFL_2P_HZ * FREQ_PER_HZ);
    localparam logic [15:0] UFL_4P_CNT  = 16'(UFL_4P_HZ * FREQ_PER_HZ);
    localparam logic [15:0] UFL_6P_CNT  = 16'(UFL_6P_HZ * FREQ_PER_HZ);
    localparam logic [15:0] UFL_8P_CNT  = 16'(UFL_8P_HZ * FREQ_PER_HZ);
    localparam logic [15:0] VEC_OP_CNT  = 16'(VEC_OP_MAX_HZ * FREQ_PER_HZ);

    // Reset values of the stored parameters
    localparam logic [15:0] RST_OP_CMD     = 16'h0000;
    localparam logic [15:0] RST_SPEED1     = 16'h0000;
    localparam logic [15:0] RST_UFL        = 16'h0258;
    localparam logic [15:0] RST_MOTOR_TYPE = 16'h0001;
    localparam logic [15:0] RST_MCM        = 16'h0000;
    localparam logic [15:0] RST_TQ_PR      = 16'h0000;
    localparam logic [15:0] RST_TQ_RG      = 16'h0000;
    localparam logic [15:0] RST_OP_MODE    = 16'h0000;
    localparam logic [15:0] RST_AIN_SW     = 16'h0000;
    localparam logic [15:0] RST_FEED_PUMP  = 16'h0000;
    localparam logic [15:0] RST_PRS_CMD    = 16'h0001;
    localparam logic [15:0] RST_PRS_UPPER  = 16'hffff;
    localparam logic [15:0] RST_PRS_LOWER  = 16'h0000;

endpackage

/* File: rtl/pcc_analog_check.sv */
// Analog channel clash detector for one candidate source value.
// Pure combinational; the caller decides the order in which hits are reported.
`timescale 1ns/1ps
module pcc_analog_check
    import pcc_pkg::*;
(
    input  wire logic [15:0] cand,
    input  wire logic [15:0] speed1,
    input  wire logic [15:0] cmp_a,
    input  wire logic [15:0] cmp_b,
    output logic             hit_speed,
    output logic             hit_a,
    output logic             hit_b
);

    logic [15:0] speed_chan;

    // Speed setting values 2..6 name a channel one below the value
    assign speed_chan = speed1 - 16'h0001;

    // A zero candidate means no channel is claimed, so nothing can clash
    always_comb begin
        hit_speed = 1'b0;
        hit_a     = 1'b0;
        hit_b     = 1'b0;
        if (cand != 16'h0000) begin
            hit_speed = (cand == speed_chan) ||
                        (speed1 >= SPEED1_EXCL_LO && speed1 <= SPEED1_EXCL_HI);
            hit_a     = (cand == cmp_a);
            hit_b     = (cand == cmp_b);
        end
    end

endmodule

/* File: rtl/pcc_checker.sv */
// Parameter store with write-time conflict checking.
// Assumes writes come from logic on ref_clk; one write per cycle at most.
`timescale 1ns/1ps
// Operation
// - Mode other than 3 needs feed pump off
// - Vector modes other than 12 bound upper frequency by poles; a motor type write does not check this bound
// - Vector modes clamp operating range to 120Hz
// - Mode refused for unpermitted motor type
// - Mode 4 needs operation command 2
// - Modes 6, 11 need operation mode 0/3
// - Modes 7-10, 12 need operation mode not 2
// - Power torque source avoids analog switching and speed uses
// - Regen torque source avoids analog switching and speed uses
// - Operation mode 1 needs mode not 6/11
// - Operation mode 2 needs mode below 6
// - Analog switching 0 needs pressure command nonzero
// - Analog switching avoids speed and torque sources
// - Feed pump on needs motor mode 3
// - Pressure command needs analog switching nonzero
// - Upper pressure not below lower pressure
// - Lower pressure not above upper pressure
// - No analog input type used twice, except that the two torque sources may share one
// - Operation command other than 0 or 2 needs mode not 4
module pcc_checker
    import pcc_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             wr_valid,
    input  wire pcc_param_t       wr_param,
    input  wire logic [15:0]      wr_data,
    output logic                  wr_done,
    output logic                  wr_refused,
    output pcc_param_t            conflict_param,
    output logic [15:0]           operation_command_selection,
    output logic [15:0]           first_speed_setting,
    output logic [15:0]           upper_frequency_limit,
    output logic [15:0]           motor_type_selection,
    output logic [15:0]           motor_control_mode,
    output logic [15:0]           torque_limit_analog_power_running,
    output logic [15:0]           torque_limit_analog_regeneration,
    output logic [15:0]           operation_mode_selection,
    output logic [15:0]           analog_input_switching,
    output logic [15:0]           feed_pump_control,
    output logic [15:0]           pressure_command,
    output logic [15:0]           upper_pressure_limit,
    output logic [15:0]           lower_pressure_limit,
    output logic [15:0]           operating_freq_max
);

    logic [15:0] op_cmd_r;
    logic [15:0] speed1_r;
    logic [15:0] ufl_r;
    logic [15:0] motor_type_r;
    logic [15:0] mcm_r;
    logic [15:0] tq_pr_r;
    logic [15:0] tq_rg_r;
    logic [15:0] op_mode_r;
    logic [15:0] ain_sw_r;
    logic [15:0] feed_r;
    logic [15:0] prs_cmd_r;
    logic [15:0] prs_up_r;
    logic [15:0] prs_lo_r;
    logic [15:0] op_max_r;
    logic        done_r;
    logic        refused_r;
    pcc_param_t  culprit_r;
    pcc_param_t  culprit_nxt;
    logic [15:0] op_max_nxt;

    logic        tp_speed;
    logic        tp_ain;
    logic        tr_speed;
    logic        tr_ain;
    logic        as_speed;
    logic        as_tp;
    logic        as_tr;

    function automatic logic is_vector(input logic [15:0] mode);
        is_vector = (mode >= MCM_VEC_FIRST) && (mode <= MCM_VEC_NO_POLE);
    endfunction

    // Upper frequency allowed for a motor type under vector control
    function automatic logic [15:0] pole_limit(input logic [15:0] mtype);
        unique case (mtype)
            16'h0000: pole_limit = UFL_2P_CNT;
            16'h0001: pole_limit = UFL_4P_CNT;
            16'h0002: pole_limit = UFL_6P_CNT;
            default:  pole_limit = UFL_8P_CNT;
        endcase
    endfunction

    function automatic logic pole_ok(input logic [15:0] mode, input logic [15:0] mtype,
                                     input logic [15:0] ufl);
        pole_ok = !is_vector(mode) || (mode == MCM_VEC_NO_POLE) || (ufl <= pole_limit(mtype));
    endfunction

    // Candidate analog sources are checked against the stored ones only
    pcc_analog_check u_tq_pr (
        .cand      (wr_data),
        .speed1    (speed1_r),
        .cmp_a     (ain_sw_r),
        .cmp_b     (tq_rg_r),
        .hit_speed (tp_speed),
        .hit_a     (tp_ain),
        .hit_b     ()
    );

    pcc_analog_check u_tq_rg (
        .cand      (wr_data),
        .speed1    (speed1_r),
        .cmp_a     (ain_sw_r),
        .cmp_b     (tq_pr_r),
        .hit_speed (tr_speed),
        .hit_a     (tr_ain),
        .hit_b     ()
    );

    pcc_analog_check u_ain (
        .cand      (wr_data),
        .speed1    (speed1_r),
        .cmp_a     (tq_pr_r),
        .cmp_b     (tq_rg_r),
        .hit_speed (as_speed),
        .hit_a     (as_tp),
        .hit_b     (as_tr)
    );

    // Each branch tests in listed order; the first failure names the culprit
    always_comb begin
        culprit_nxt = PAR_NONE;
        unique case (wr_param)
            PAR_MCM: begin
                if (wr_data != MCM_FEED_PUMP && feed_r != 16'h0000) begin
                    culprit_nxt = PAR_FEED_PUMP;
                end else if (!pole_ok(wr_data, motor_type_r, ufl_r)) begin
                    culprit_nxt = PAR_UFL;
                end else if (is_vector(wr_data) && motor_type_r >= VEC_MOTOR_TYPES) begin
                    culprit_nxt = PAR_MOTOR_TYPE;
                end else if (wr_data == MCM_OPCMD_ONLY && op_cmd_r != OPCMD_REQ) begin
                    culprit_nxt = PAR_OP_CMD;
                end else if ((wr_data == MCM_VEC_FIRST || wr_data == MCM_VEC_B) &&
                             op_mode_r != 16'h0000 && op_mode_r != OPMODE_THREE) begin
                    culprit_nxt = PAR_OP_MODE;
                end else if (is_vector(wr_data) && wr_data != MCM_VEC_FIRST &&
                             wr_data != MCM_VEC_B && op_mode_r == OPMODE_TWO) begin
                    culprit_nxt = PAR_OP_MODE;
                end
            end
            PAR_OP_CMD: begin
                if (wr_data != 16'h0000 && wr_data != OPCMD_REQ && mcm_r == MCM_OPCMD_ONLY) begin
                    culprit_nxt = PAR_MCM;
                end
            end
            PAR_SPEED1: begin
                // Speed setting claims a channel too, so the same no-sharing holds here
                if (wr_data >= SPEED1_EXCL_LO && wr_data <= SPEED1_EXCL_HI) begin
                    if (ain_sw_r != 16'h0000) begin
                        culprit_nxt = PAR_AIN_SW;
                    end else if (tq_pr_r != 16'h0000) begin
                        culprit_nxt = PAR_TQ_PR;
                    end else if (tq_rg_r != 16'h0000) begin
                        culprit_nxt = PAR_TQ_RG;
                    end
                end else if (wr_data >= SPEED1_SHARE_LO) begin
                    if (ain_sw_r == wr_data - 16'h0001) begin
                        culprit_nxt = PAR_AIN_SW;
                    end else if (tq_pr_r == wr_data - 16'h0001) begin
                        culprit_nxt = PAR_TQ_PR;
                    end else if (tq_rg_r == wr_data - 16'h0001) begin
                        culprit_nxt = PAR_TQ_RG;
                    end
                end
            end
            PAR_UFL: begin
                if (!pole_ok(mcm_r, motor_type_r, wr_data)) begin
                    culprit_nxt = PAR_MCM;
                end
            end
            PAR_MOTOR_TYPE: begin
                if (is_vector(mcm_r) && wr_data >= VEC_MOTOR_TYPES) begin
                    culprit_nxt = PAR_MCM;
                end
            end
            PAR_TQ_PR: begin
                if (tp_ain) begin
                    culprit_nxt = PAR_AIN_SW;
                end else if (tp_speed) begin
                    culprit_nxt = PAR_SPEED1;
                end
            end
            PAR_TQ_RG: begin
                if (tr_ain) begin
                    culprit_nxt = PAR_AIN_SW;
                end else if (tr_speed) begin
                    culprit_nxt = PAR_SPEED1;
                end
            end
            PAR_OP_MODE: begin
                if (wr_data == OPMODE_ONE && (mcm_r == MCM_VEC_FIRST || mcm_r == MCM_VEC_B)) begin
                    culprit_nxt = PAR_MCM;
                end else if (wr_data == OPMODE_TWO && mcm_r >= MCM_VEC_FIRST) begin
                    culprit_nxt = PAR_MCM;
                end
            end
            PAR_AIN_SW: begin
                if (wr_data == 16'h0000) begin
                    if (prs_cmd_r == 16'h0000) begin
                        culprit_nxt = PAR_PRS_CMD;
                    end
                end else if (as_speed) begin
                    culprit_nxt = PAR_SPEED1;
                end else if (as_tp) begin
                    culprit_nxt = PAR_TQ_PR;
                end else if (as_tr) begin
                    culprit_nxt = PAR_TQ_RG;
                end
            end
            PAR_FEED_PUMP: begin
                if (wr_data != 16'h0000 && mcm_r != MCM_FEED_PUMP) begin
                    culprit_nxt = PAR_MCM;
                end
            end
            PAR_PRS_CMD: begin
                if (wr_data != 16'h0000 && ain_sw_r == 16'h0000) begin
                    culprit_nxt = PAR_AIN_SW;
                end
            end
            PAR_PRS_UPPER: begin
                if (wr_data < prs_lo_r) begin
                    culprit_nxt = PAR_PRS_LOWER;
                end
            end
            PAR_PRS_LOWER: begin
                if (wr_data > prs_up_r) begin
                    culprit_nxt = PAR_PRS_UPPER;
                end
            end
            default: culprit_nxt = PAR_NONE;
        endcase
    end

    // Result of each write, one cycle after it is taken
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            culprit_r <= PAR_NONE;
        end else begin
            done_r <= wr_valid && wr_param != PAR_NONE;
            if (wr_valid && wr_param != PAR_NONE) begin
                refused_r <= culprit_nxt != PAR_NONE;
                culprit_r <= culprit_nxt;
            end
        end
    end

    // Stored values change only on an accepted write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_cmd_r     <= RST_OP_CMD;
            speed1_r     <= RST_SPEED1;
            ufl_r        <= RST_UFL;
            motor_type_r <= RST_MOTOR_TYPE;
            mcm_r        <= RST_MCM;
            tq_pr_r      <= RST_TQ_PR;
            tq_rg_r      <= RST_TQ_RG;
            op_mode_r    <= RST_OP_MODE;
            ain_sw_r     <= RST_AIN_SW;
            feed_r       <= RST_FEED_PUMP;
            prs_cmd_r    <= RST_PRS_CMD;
            prs_up_r     <= RST_PRS_UPPER;
            prs_lo_r     <= RST_PRS_LOWER;
        end else if (wr_valid && culprit_nxt == PAR_NONE) begin
            unique case (wr_param)
                PAR_OP_CMD:     op_cmd_r     <= wr_data;
                PAR_SPEED1:     speed1_r     <= wr_data;
                PAR_UFL:        ufl_r        <= wr_data;
                PAR_MOTOR_TYPE: motor_type_r <= wr_data;
                PAR_MCM:        mcm_r        <= wr_data;
                PAR_TQ_PR:      tq_pr_r      <= wr_data;
                PAR_TQ_RG:      tq_rg_r      <= wr_data;
                PAR_OP_MODE:    op_mode_r    <= wr_data;
                PAR_AIN_SW:     ain_sw_r     <= wr_data;
                PAR_FEED_PUMP:  feed_r       <= wr_data;
                PAR_PRS_CMD:    prs_cmd_r    <= wr_data;
                PAR_PRS_UPPER:  prs_up_r     <= wr_data;
                PAR_PRS_LOWER:  prs_lo_r     <= wr_data;
                default:        op_cmd_r     <= op_cmd_r;
            endcase
        end
    end

    // Vector modes cap the real operating range even if the limit is set higher
    always_comb begin
        op_max_nxt = ufl_r;
        if (is_vector(mcm_r) && ufl_r > VEC_OP_CNT) begin
            op_max_nxt = VEC_OP_CNT;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_max_r <= RST_UFL;
        end else begin
            op_max_r <= op_max_nxt;
        end
    end

    assign wr_done                           = done_r;
    assign wr_refused                        = refused_r;
    assign conflict_param                    = culprit_r;
    assign operation_command_selection       = op_cmd_r;
    assign first_speed_setting               = speed1_r;
    assign upper_frequency_limit             = ufl_r;
    assign motor_type_selection              = motor_type_r;
    assign motor_control_mode                = mcm_r;
    assign torque_limit_analog_power_running = tq_pr_r;
    assign torque_limit_analog_regeneration  = tq_rg_r;
    assign operation_mode_selection          = op_mode_r;
    assign analog_input_switching            = ain_sw_r;
    assign feed_pump_control                 = feed_r;
    assign pressure_command                  = prs_cmd_r;
    assign upper_pressure_limit              = prs_up_r;
    assign lower_pressure_limit              = prs_lo_r;
    assign operating_freq_max                = op_max_r;

endmodule

/* File: tb/pcc_checker_assertions.sv */
// Concurrent checks on the parameter conflict checker's ports.
// Assumes one ref_clk domain and the async active-low rstn.
`timescale 1ns/1ps
module pcc_chk_props
    import pcc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        wr_valid,
    input wire pcc_param_t  wr_param,
    input wire logic [15:0] wr_data,
    input wire logic        wr_done,
    input wire logic        wr_refused,
    input wire pcc_param_t  conflict_param,
    input wire logic [15:0] upper_frequency_limit,
    input wire logic [15:0] motor_control_mode,
    input wire logic [15:0] operation_command_selection,
    input wire logic [15:0] operation_mode_selection,
    input wire logic [15:0] analog_input_switching,
    input wire logic [15:0] feed_pump_control,
    input wire logic [15:0] pressure_command,
    input wire logic [15:0] upper_pressure_limit,
    input wire logic [15:0] lower_pressure_limit,
    input wire logic [15:0] operating_freq_max
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    wire logic take = wr_valid && (wr_param != PAR_NONE);
    wire logic [15:0] mcm = motor_control_mode;
    wire logic vec = (mcm >= 16'h0006) && (mcm <= 16'h000c);

    sequence s_refuse(pcc_param_t p);
        wr_done && wr_refused && (conflict_param == p);
    endsequence
    sequence s_accept;
        wr_done && !wr_refused && (conflict_param == PAR_NONE);
    endsequence

    a_done_after_take: assert property (take |=> wr_done) else $error("no done");
    a_no_stray_done: assert property (!take |=> !wr_done) else $error("stray done");
    a_mode_pump_off: assert property (take && wr_param == PAR_MCM && wr_data != MCM_FEED_PUMP
        && feed_pump_control != 16'h0000 |=> s_refuse(PAR_FEED_PUMP) ##0 $stable(motor_control_mode))
        else $error("pump on");
    a_mode4_opcmd: assert property (take && wr_param == PAR_MCM && wr_data == MCM_OPCMD_ONLY
        && feed_pump_control == 16'h0000 && operation_command_selection != OPCMD_REQ
        |=> s_refuse(PAR_OP_CMD)) else $error("mode 4");
    a_vec_opmode: assert property (take && wr_param == PAR_MCM && wr_data >= 16'h0007
        && wr_data <= 16'h000c && operation_mode_selection == OPMODE_TWO |=> wr_done && wr_refused)
        else $error("opmode 2");
    a_opmode_mode: assert property (take && wr_param == PAR_OP_MODE && ((wr_data == OPMODE_ONE
        && (mcm == MCM_VEC_FIRST || mcm == MCM_VEC_B)) || (wr_data == OPMODE_TWO && mcm >= 16'h0006))
        |=> s_refuse(PAR_MCM) ##0 $stable(operation_mode_selection)) else $error("opmode");
    a_pump_mode3: assert property (take && wr_param == PAR_FEED_PUMP && wr_data != 16'h0000
        && mcm != MCM_FEED_PUMP |=> s_refuse(PAR_MCM)) else $error("pump mode");
    a_ain_zero_prs: assert property (take && wr_param == PAR_AIN_SW && wr_data == 16'h0000
        && pressure_command == 16'h0000 |=> s_refuse(PAR_PRS_CMD)) else $error("switch 0");
    a_prs_needs_ain: assert property (take && wr_param == PAR_PRS_CMD && wr_data != 16'h0000
        && analog_input_switching == 16'h0000 |=> s_refuse(PAR_AIN_SW)) else $error("prs cmd");
    a_upper_order: assert property (take && wr_param == PAR_PRS_UPPER && wr_data < lower_pressure_limit
        |=> s_refuse(PAR_PRS_LOWER) ##0 $stable(upper_pressure_limit)) else $error("upper low");
    a_upper_takes: assert property (take && wr_param == PAR_PRS_UPPER && wr_data >= lower_pressure_limit
        |=> s_accept ##0 upper_pressure_limit == $past(wr_data)) else $error("no store");
    a_lower_order: assert property (take && wr_param == PAR_PRS_LOWER && wr_data > upper_pressure_limit
        |=> s_refuse(PAR_PRS_UPPER)) else $error("lower high");
    a_freq_clamp: assert property ($stable(mcm) && $stable(upper_frequency_limit)
        |-> operating_freq_max == ((vec && upper_frequency_limit > VEC_OP_CNT) ? VEC_OP_CNT
        : upper_frequency_limit)) else $error("no clamp");
endmodule

bind pcc_checker pcc_chk_props u_chk (.*);

/* File: tb/pcc_panel_model.sv */
// Operator panel model: issues parameter writes one per clock.
// Assumes the checker takes a write at the edge where wr_valid is high.
`timescale 1ns/1ps
module pcc_panel_model
    import pcc_pkg::*;
(
    input  wire logic   ref_clk,
    output logic        wr_valid,
    output pcc_param_t  wr_param,
    output logic [15:0] wr_data
);
    initial begin
        wr_valid = 1'b0;
        wr_param = PAR_NONE;
        wr_data  = 16'h0000;
    end

    // Channel allocation is left to the caller; clashing tables test the refusals
    task automatic drive(input pcc_param_t p, input logic [15:0] d, input logic last);
        @(posedge ref_clk);
        wr_valid <= 1'b1;
        wr_param <= p;
        wr_data  <= d;
        if (last) begin
            @(posedge ref_clk);
            wr_valid <= 1'b0;
            wr_param <= PAR_NONE;
            wr_data  <= ~d;
        end
    endtask
endmodule

/* File: tb/pcc_checker_tb_top.sv */
// Self-checking bench for the parameter conflict checker.
// Assumes the panel model as write source and the bound port checker.
`timescale 1ns/1ps
module pcc_checker_tb_top
    import pcc_pkg::*;
;
    typedef struct {pcc_param_t p; logic [15:0] d; logic r; pcc_param_t c;} pcc_tb_row_t;
    localparam int NR = 46;
    pcc_tb_row_t rows [NR] = '{
        '{PAR_FEED_PUMP, 16'h1, 1'b1, PAR_MCM}, '{PAR_MCM, 16'h4, 1'b1, PAR_OP_CMD},
        '{PAR_OP_CMD, 16'h2, 1'b0, PAR_NONE}, '{PAR_MCM, 16'h4, 1'b0, PAR_NONE},
        '{PAR_OP_CMD, 16'h1, 1'b1, PAR_MCM}, '{PAR_MCM, 16'h3, 1'b0, PAR_NONE},
        '{PAR_FEED_PUMP, 16'h1, 1'b0, PAR_NONE}, '{PAR_MCM, 16'h0, 1'b1, PAR_FEED_PUMP},
        '{PAR_FEED_PUMP, 16'h0, 1'b0, PAR_NONE}, '{PAR_OP_MODE, 16'h2, 1'b0, PAR_NONE},
        '{PAR_MCM, 16'h6, 1'b1, PAR_OP_MODE}, '{PAR_MCM, 16'h8, 1'b1, PAR_OP_MODE},
        '{PAR_MCM, 16'hc, 1'b1, PAR_OP_MODE}, '{PAR_OP_MODE, 16'h3, 1'b0, PAR_NONE},
        '{PAR_MCM, 16'hb, 1'b0, PAR_NONE}, '{PAR_OP_MODE, 16'h1, 1'b1, PAR_MCM},
        '{PAR_OP_MODE, 16'h2, 1'b1, PAR_MCM}, '{PAR_UFL, 16'h578, 1'b1, PAR_MCM},
        '{PAR_UFL, 16'h514, 1'b0, PAR_NONE}, '{PAR_MCM, 16'h3, 1'b0, PAR_NONE},
        '{PAR_MOTOR_TYPE, 16'h0, 1'b0, PAR_NONE}, '{PAR_MCM, 16'h7, 1'b1, PAR_UFL},
        '{PAR_MOTOR_TYPE, 16'h4, 1'b0, PAR_NONE}, '{PAR_UFL, 16'h1f4, 1'b0, PAR_NONE},
        '{PAR_MCM, 16'h7, 1'b1, PAR_MOTOR_TYPE}, '{PAR_PRS_UPPER, 16'h5, 1'b0, PAR_NONE},
        '{PAR_PRS_LOWER, 16'h6, 1'b1, PAR_PRS_UPPER}, '{PAR_PRS_LOWER, 16'h5, 1'b0, PAR_NONE},
        '{PAR_PRS_UPPER, 16'h4, 1'b1, PAR_PRS_LOWER}, '{PAR_PRS_CMD, 16'h0, 1'b0, PAR_NONE},
        '{PAR_AIN_SW, 16'h0, 1'b1, PAR_PRS_CMD}, '{PAR_PRS_CMD, 16'h1, 1'b1, PAR_AIN_SW},
        '{PAR_AIN_SW, 16'h2, 1'b0, PAR_NONE}, '{PAR_PRS_CMD, 16'h1, 1'b0, PAR_NONE},
        '{PAR_TQ_PR, 16'h2, 1'b1, PAR_AIN_SW}, '{PAR_TQ_PR, 16'h1, 1'b0, PAR_NONE},
        '{PAR_TQ_RG, 16'h2, 1'b1, PAR_AIN_SW}, '{PAR_TQ_RG, 16'h3, 1'b0, PAR_NONE},
        '{PAR_AIN_SW, 16'h1, 1'b1, PAR_TQ_PR}, '{PAR_AIN_SW, 16'h3, 1'b1, PAR_TQ_RG},
        '{PAR_SPEED1, 16'h8, 1'b1, PAR_AIN_SW}, '{PAR_SPEED1, 16'h3, 1'b1, PAR_AIN_SW},
        '{PAR_SPEED1, 16'h5, 1'b0, PAR_NONE}, '{PAR_TQ_PR, 16'h4, 1'b1, PAR_SPEED1},
        '{PAR_TQ_RG, 16'h4, 1'b1, PAR_SPEED1}, '{PAR_AIN_SW, 16'h4, 1'b1, PAR_SPEED1}};
    logic [15:0] rst_vals [16] = '{16'h0, RST_OP_CMD, RST_SPEED1, RST_UFL, RST_MOTOR_TYPE, RST_MCM,
        RST_TQ_PR, RST_TQ_RG, RST_OP_MODE, RST_AIN_SW, RST_FEED_PUMP, RST_PRS_CMD, RST_PRS_UPPER,
        RST_PRS_LOWER, 16'h0, 16'h0};
    logic [15:0] st [16];
    logic               ref_clk = 1'b0;
    logic               rstn    = 1'b0;
    logic               wr_valid, wr_done, wr_refused;
    pcc_param_t         wr_param, conflict_param;
    logic [15:0]        wr_data, opc, sp1, ufl, mty, mcm, tpr, trg, opm, ain, fpc, prc, pup, plo, fmx;
    int                 n_mismatch      = 0;
    int                 samples_checked = 0;

    always #12.5 ref_clk = ~ref_clk;

    pcc_panel_model u_panel (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr_param(wr_param), .wr_data(wr_data));

    pcc_checker u_dut (.ref_clk(ref_clk), .rstn(rstn), .wr_valid(wr_valid), .wr_param(wr_param),
        .wr_data(wr_data), .wr_done(wr_done), .wr_refused(wr_refused), .conflict_param(conflict_param),
        .operation_command_selection(opc), .first_speed_setting(sp1), .upper_frequency_limit(ufl),
        .motor_type_selection(mty), .motor_control_mode(mcm), .torque_limit_analog_power_running(tpr),
        .torque_limit_analog_regeneration(trg), .operation_mode_selection(opm),
        .analog_input_switching(ain), .feed_pump_control(fpc), .pressure_command(prc),
        .upper_pressure_limit(pup), .lower_pressure_limit(plo), .operating_freq_max(fmx));

    function automatic logic [15:0] seen_val(input pcc_param_t p);
        logic [15:0] v [16];
        v = '{16'h0, opc, sp1, ufl, mty, mcm, tpr, trg, opm, ain, fpc, prc, pup, plo, 16'h0, 16'h0};
        return v[p];
    endfunction

    function automatic logic [15:0] exp_fmax();
        return (st[PAR_MCM] >= 16'h6 && st[PAR_MCM] <= 16'hc && st[PAR_UFL] > VEC_OP_CNT) ? VEC_OP_CNT : st[PAR_UFL];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic check_reset();
        st = rst_vals;
        for (int i = 1; i < 14; i++) begin
            check(seen_val(pcc_param_t'(i)), st[i], "reset value");
        end
        check(16'(wr_refused), 16'h0, "reset refused");
        check(fmx, exp_fmax(), "reset freq max");
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        check_reset();
        $display("test reset done");
        for (int i = 0; i < NR; i++) begin
            u_panel.drive(rows[i].p, rows[i].d, 1'b1);
            #1;
            check(16'(wr_done), 16'h1, "done");
            check(16'(wr_refused), 16'(rows[i].r), "refused");
            check(16'(conflict_param), 16'(rows[i].c), "culprit");
            if (!rows[i].r) st[rows[i].p] = rows[i].d;
            check(seen_val(rows[i].p), st[rows[i].p], "stored");
            @(posedge ref_clk);
            #1;
            check(fmx, exp_fmax(), "freq max");
        end
        $display("test table done");
        u_panel.drive(PAR_PRS_UPPER, 16'h9, 1'b0);
        u_panel.drive(PAR_PRS_LOWER, 16'ha, 1'b1);
        #1;
        check(pup, 16'h9, "pair 1");
        check(16'(conflict_param), 16'(PAR_PRS_UPPER), "pair 2");
        check(plo, st[PAR_PRS_LOWER], "lower kept");
        $display("test back to back done");
        u_panel.drive(PAR_NONE, 16'h1, 1'b1);
        #1;
        check(16'(wr_done), 16'h0, "no-op");
        $display("test no-op done");
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        check_reset();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
